// [iorb_regs.svh]
// register indices, field positions, reset values and timing of the option bank
`ifndef IORB_REGS_SVH
`define IORB_REGS_SVH

// register indices; byte address is four times the index
`define IORB_IDX_PA_DEB 7'h75
`define IORB_IDX_PA_EDGE 7'h76
`define IORB_IDX_PA_NOPD 7'h77
`define IORB_IDX_PB_NOPD 7'h78
`define IORB_IDX_PB_OD 7'h79
`define IORB_IDX_SP_OD 7'h7A
`define IORB_IDX_PB_FSEL 7'h7B
`define IORB_IDX_COMBO1 7'h7C
`define IORB_IDX_COMBO2 7'h7D
`define IORB_IDX_SP_NOPD 7'h7E
`define IORB_IDX_TEST 7'h7F

// number of storing option registers and their width
`define IORB_NREG 10
`define IORB_OPT_W 4
`define IORB_OPT_RESET 4'h0

// fields of the clock-out and sleep-reset register
`define IORB_FSEL_1HZ_BIT 0
`define IORB_FSEL_1KHZ_BIT 1
`define IORB_FSEL_32KHZ_BIT 2
`define IORB_FSEL_WAKE_BIT 3

// clock rate and output frequencies, in hertz
`define IORB_CLK_HZ 200000000
`define IORB_F_1HZ 1
`define IORB_F_1KHZ 1000
`define IORB_F_32KHZ 32000

`endif

// [iorb_pkg.sv]
// types shared by the option register bank
`include "iorb_regs.svh"

package iorb_pkg;

  // apb request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } iorb_apb_req_t;

  // apb answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } iorb_apb_rsp_t;

  // whole state of the bank
  typedef struct packed {
    logic [`IORB_NREG-1:0][`IORB_OPT_W-1:0] opt;
    logic [31:0] prdata;
    logic [3:0] pa_prev;
    logic [3:0] pa_irq;
    logic [2:0][26:0] div_cnt;
    logic [2:0] clk_tgl;
    logic reset_req;
  } iorb_state_t;

endpackage : iorb_pkg

// [iorb_option_bank.sv]
// option register bank: port configuration registers on apb with port gating
//
// Behaviour
// - only power-on reset clears; resets elsewhere ignored
// - debounce bit one bypasses port A debouncer
// - edge bit zero rising, one falling
// - port A pulldown bit one disconnects pulldown
// - port B pulldown bit one removes pulldown
// - output type bit one selects open drain
// - bits 0..2 route 1Hz, 1kHz, 32kHz out
// - bit 3 allows combo reset from sleep
// - two select registers define port A combo
// - serial pulldown bit one disconnects pulldown
// - port A pullup excludes its pulldown
// - port B pullup only in open drain
// - default build: A pulldowns, B both paths
`timescale 1ns/1ps

`include "iorb_regs.svh"

module iorb_option_bank
  import iorb_pkg::*;
#(
  parameter int unsigned HALF_1HZ = `IORB_CLK_HZ / (2 * `IORB_F_1HZ),
  parameter int unsigned HALF_1KHZ = `IORB_CLK_HZ / (2 * `IORB_F_1KHZ),
  parameter logic [3:0] PA_PU_MASK = 4'h0,
  parameter logic [3:0] PA_PD_MASK = 4'hF,
  parameter logic [3:0] PB_PU_MASK = 4'hF,
  parameter logic [3:0] PB_PD_MASK = 4'hF,
  parameter logic [3:0] SP_PD_MASK = 4'hF
) (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire iorb_apb_req_t apb_req_i,
  output iorb_apb_rsp_t apb_rsp_o,
  input wire logic [3:0] pa_raw_i,
  input wire logic [3:0] pa_debounced_i,
  input wire logic sleep_i,
  output logic [3:0] pa_irq_pulse_o,
  output logic [3:0] pa_pullup_en_o,
  output logic [3:0] pa_pulldown_en_o,
  output logic [3:0] pb_pullup_en_o,
  output logic [3:0] pb_pulldown_en_o,
  output logic [3:0] pb_open_drain_o,
  output logic [2:0] pb_clock_out_o,
  output logic [3:0] sp_open_drain_o,
  output logic [3:0] sp_pulldown_en_o,
  output logic port_a_reset_o
);

  // slots of the storing registers in the state array
  localparam int S_PA_DEB = `IORB_IDX_PA_DEB - `IORB_IDX_PA_DEB;
  localparam int S_PA_EDGE = `IORB_IDX_PA_EDGE - `IORB_IDX_PA_DEB;
  localparam int S_PA_NOPD = `IORB_IDX_PA_NOPD - `IORB_IDX_PA_DEB;
  localparam int S_PB_NOPD = `IORB_IDX_PB_NOPD - `IORB_IDX_PA_DEB;
  localparam int S_PB_OD = `IORB_IDX_PB_OD - `IORB_IDX_PA_DEB;
  localparam int S_SP_OD = `IORB_IDX_SP_OD - `IORB_IDX_PA_DEB;
  localparam int S_FSEL = `IORB_IDX_PB_FSEL - `IORB_IDX_PA_DEB;
  localparam int S_COMBO1 = `IORB_IDX_COMBO1 - `IORB_IDX_PA_DEB;
  localparam int S_COMBO2 = `IORB_IDX_COMBO2 - `IORB_IDX_PA_DEB;
  localparam int S_SP_NOPD = `IORB_IDX_SP_NOPD - `IORB_IDX_PA_DEB;
  localparam logic [3:0] SLOT_TEST = 4'(`IORB_IDX_TEST - `IORB_IDX_PA_DEB);
  localparam logic [3:0] SLOT_NONE = 4'hF;

  // the 32 kHz half period fits a short count, the others are parameters
  localparam int unsigned HALF_32KHZ = `IORB_CLK_HZ / (2 * `IORB_F_32KHZ);
  localparam logic [2:0][26:0] HALF_TAB = {
    27'(HALF_32KHZ - 1),
    27'(HALF_1KHZ - 1),
    27'(HALF_1HZ - 1)
  };

  // maps a byte address onto a register slot, or none
  function automatic logic [3:0] addr_slot(input logic [11:0] a);
    logic [6:0] idx;
    idx = a[8:2];
    if (a[11:9] != 3'h0 || idx < `IORB_IDX_PA_DEB || idx > `IORB_IDX_TEST) begin
      addr_slot = SLOT_NONE;
    end else begin
      addr_slot = 4'(idx - `IORB_IDX_PA_DEB);
    end
  endfunction : addr_slot

  // a combination hits when its selection is not empty and every selected input is high
  function automatic logic combo_hit(input logic [3:0] sel, input logic [3:0] pins);
    combo_hit = (sel != 4'h0) && ((pins & sel) == sel);
  endfunction : combo_hit

  iorb_state_t s_q;
  iorb_state_t s_d;
  logic [3:0] slot;
  logic setup_rd;
  logic access;
  logic wr_en;
  logic [3:0] pa_deb_byp;
  logic [3:0] pa_edge_sel;
  logic [3:0] pa_no_pd;
  logic [3:0] pb_no_pd;
  logic [3:0] pb_od;
  logic [3:0] sp_od;
  logic [3:0] fsel;
  logic [3:0] sp_no_pd;
  logic [3:0] pa_src;
  logic [3:0] pa_rise;
  logic [3:0] pa_fall;
  logic combo_now;

  // apb decode; the bank always answers without wait states
  assign slot = addr_slot(apb_req_i.paddr);
  assign setup_rd = apb_req_i.psel & ~apb_req_i.penable & ~apb_req_i.pwrite;
  assign access = apb_req_i.psel & apb_req_i.penable;
  assign wr_en = access & apb_req_i.pwrite & (slot < SLOT_TEST);

  // named views of the stored options
  assign pa_deb_byp = s_q.opt[S_PA_DEB];
  assign pa_edge_sel = s_q.opt[S_PA_EDGE];
  assign pa_no_pd = s_q.opt[S_PA_NOPD];
  assign pb_no_pd = s_q.opt[S_PB_NOPD];
  assign pb_od = s_q.opt[S_PB_OD];
  assign sp_od = s_q.opt[S_SP_OD];
  assign fsel = s_q.opt[S_FSEL];
  assign sp_no_pd = s_q.opt[S_SP_NOPD];

  // interrupt source per input: raw pin when bypassed, else debouncer
  assign pa_src = (pa_deb_byp & pa_raw_i) | (~pa_deb_byp & pa_debounced_i);
  assign pa_rise = pa_src & ~s_q.pa_prev;
  assign pa_fall = ~pa_src & s_q.pa_prev;

  // port A combination, either selection set
  assign combo_now = combo_hit(s_q.opt[S_COMBO1], pa_raw_i)
                   | combo_hit(s_q.opt[S_COMBO2], pa_raw_i);

  // next state of the whole bank
  always_comb begin
    s_d = s_q;
    // cpu write lands at the access edge, visible the cycle after
    if (wr_en) begin
      s_d.opt[slot] = apb_req_i.pwdata[3:0];
    end
    // read data is fetched in setup so that it comes from a flop
    if (setup_rd) begin
      s_d.prdata = 32'h0;
      if (slot < SLOT_TEST) begin
        s_d.prdata[3:0] = s_q.opt[slot];
      end
    end
    // edge pick per input; a pulse lasts one cycle
    s_d.pa_prev = pa_src;
    s_d.pa_irq = (~pa_edge_sel & pa_rise) | (pa_edge_sel & pa_fall);
    // dividers run only while their output is routed, saving toggles
    for (int i = 0; i < 3; i++) begin
      if (!fsel[i]) begin
        s_d.div_cnt[i] = 27'h0;
        s_d.clk_tgl[i] = 1'b0;
      end else if (s_q.div_cnt[i] == HALF_TAB[i]) begin
        s_d.div_cnt[i] = 27'h0;
        s_d.clk_tgl[i] = ~s_q.clk_tgl[i];
      end else begin
        s_d.div_cnt[i] = s_q.div_cnt[i] + 27'h1;
      end
    end
    // while asleep only the wake enable lets the combo reset through
    s_d.reset_req = combo_now & (~sleep_i | fsel[`IORB_FSEL_WAKE_BIT]);
  end

  // reset_n_i is the power-on reset; no other reset touches this bank
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // apb answer; error on holes and on writes to the factory test slot
  always_comb begin
    apb_rsp_o.prdata = s_q.prdata;
    apb_rsp_o.pready = 1'b1;
    apb_rsp_o.pslverr = access & ((slot == SLOT_NONE)
                      | (apb_req_i.pwrite & (slot == SLOT_TEST)));
  end

  // pull gating: mask options fix the paths, registers switch off all but the port A pullups
  assign pa_pullup_en_o = PA_PU_MASK;
  assign pa_pulldown_en_o = PA_PD_MASK & ~PA_PU_MASK & ~pa_no_pd;
  assign pb_pullup_en_o = PB_PU_MASK & pb_od;
  assign pb_pulldown_en_o = PB_PD_MASK & ~pb_no_pd;
  assign sp_pulldown_en_o = SP_PD_MASK & ~sp_no_pd;

  // output styles straight from the registers
  assign pb_open_drain_o = pb_od;
  assign sp_open_drain_o = sp_od;

  // registered outputs
  assign pa_irq_pulse_o = s_q.pa_irq;
  assign pb_clock_out_o = s_q.clk_tgl;
  assign port_a_reset_o = s_q.reset_req;

  // checks on the bank's own behaviour
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!reset_n_i);

  a_opt_only_write: assert property (
    (s_q.opt != $past(s_q.opt)) |-> $past(wr_en)
  ) else $error("option register changed without a cpu write");

  a_debounce_bypass: assert property (
    (pa_deb_byp[0] && $past(pa_deb_byp[0]) && !pa_edge_sel[0] && $rose(pa_raw_i[0]))
    |=> pa_irq_pulse_o[0]
  ) else $error("bypassed raw rise gave no interrupt pulse");

  a_edge_falling: assert property (
    (!pa_deb_byp[1] && $past(!pa_deb_byp[1]) && pa_edge_sel[1] && $fell(pa_debounced_i[1]))
    |=> pa_irq_pulse_o[1] ##1 !pa_irq_pulse_o[1]
  ) else $error("falling edge not flagged for exactly one cycle");

  a_edge_rising_only: assert property (
    (!pa_edge_sel[2] && !pa_deb_byp[2] && $past(!pa_deb_byp[2]) && $fell(pa_debounced_i[2]))
    |=> !pa_irq_pulse_o[2]
  ) else $error("falling edge flagged while rising edge selected");

  a_pa_pull_excl: assert property (
    ((pa_pullup_en_o & pa_pulldown_en_o) == 4'h0)
    && ((pa_pulldown_en_o & pa_no_pd) == 4'h0)
  ) else $error("port A pull paths in conflict");

  a_pb_pull_gate: assert property (
    ((pb_pullup_en_o & ~pb_open_drain_o) == 4'h0)
    && ((pb_pulldown_en_o & pb_no_pd) == 4'h0)
  ) else $error("port B pull enabled against its options");

  a_od_write_follow: assert property (
    (wr_en && slot == 4'(S_PB_OD))
    |=> pb_open_drain_o == $past(apb_req_i.pwdata[3:0])
  ) else $error("open drain select did not follow the write");

  a_sp_pd_write: assert property (
    (wr_en && slot == 4'(S_SP_NOPD))
    |=> sp_pulldown_en_o == (SP_PD_MASK & ~$past(apb_req_i.pwdata[3:0]))
  ) else $error("serial pulldown did not follow the write");

  a_clk_out_off: assert property (
    !fsel[0] |=> !pb_clock_out_o[0] && s_q.div_cnt[0] == 27'h0
  ) else $error("1 Hz output active while disabled");

  a_clk_32k_period: assert property (
    ($past(fsel[2]) && $changed(pb_clock_out_o[2]))
    |=> (!$past(fsel[2]) || $stable(pb_clock_out_o[2]))[*8]
  ) else $error("32 kHz output toggled twice within eight cycles");

  a_wake_blocked: assert property (
    (sleep_i && !fsel[`IORB_FSEL_WAKE_BIT]) |=> !port_a_reset_o
  ) else $error("combo reset escaped sleep without wake enable");

  a_combo_reset: assert property (
    (combo_now && (!sleep_i || fsel[`IORB_FSEL_WAKE_BIT])) |=> port_a_reset_o
  ) else $error("selected port A combination gave no reset");

  a_read_back: assert property (
    (setup_rd && slot < SLOT_TEST) ##1 access
    |-> apb_rsp_o.prdata == {28'h0, $past(s_q.opt[slot])}
  ) else $error("read data differs from stored option");

  // bus side: refused writes, error answer and held read data
  a_write_refused: assert property (
    (access && apb_req_i.pwrite && slot >= SLOT_TEST)
    |=> $stable(s_q.opt)
  ) else $error("refused write changed an option register");

  a_err_hole: assert property (
    (access && slot == SLOT_NONE)
    |-> apb_rsp_o.pslverr
  ) else $error("unmapped access answered without error");

  a_err_clean: assert property (
    (access && slot < SLOT_TEST)
    |-> !apb_rsp_o.pslverr
  ) else $error("mapped option access answered with error");

  a_rd_upper_zero: assert property (
    (access && !apb_req_i.pwrite)
    |-> apb_rsp_o.prdata[31:4] == 28'h0
  ) else $error("read data has bits above the option nibble");

  a_prdata_hold: assert property (
    !setup_rd
    |=> $stable(apb_rsp_o.prdata)
  ) else $error("read data changed outside a read setup");

  // register writes reach the pin controls one cycle later
  a_pa_nopd_write: assert property (
    (wr_en && slot == 4'(S_PA_NOPD))
    |=> pa_pulldown_en_o == (PA_PD_MASK & ~PA_PU_MASK & ~$past(apb_req_i.pwdata[3:0]))
  ) else $error("port A pulldown did not follow the write");

  a_pb_nopd_write: assert property (
    (wr_en && slot == 4'(S_PB_NOPD))
    |=> pb_pulldown_en_o == (PB_PD_MASK & ~$past(apb_req_i.pwdata[3:0]))
  ) else $error("port B pulldown did not follow the write");

  a_sp_od_write: assert property (
    (wr_en && slot == 4'(S_SP_OD))
    |=> sp_open_drain_o == $past(apb_req_i.pwdata[3:0])
  ) else $error("serial open drain select did not follow the write");

  a_pb_pu_write: assert property (
    (wr_en && slot == 4'(S_PB_OD))
    |=> pb_pullup_en_o == (PB_PU_MASK & $past(apb_req_i.pwdata[3:0]))
  ) else $error("port B pullup did not follow the open drain write");

  a_pull_masks: assert property (
    ((pa_pulldown_en_o & ~PA_PD_MASK) == 4'h0) && (pa_pullup_en_o == PA_PU_MASK)
    && ((pb_pulldown_en_o & ~PB_PD_MASK) == 4'h0) && ((pb_pullup_en_o & ~PB_PU_MASK) == 4'h0)
  ) else $error("pull enabled on a path the mask option leaves out");

  // interrupt source choice and edge choice per input
  a_raw_ignored: assert property (
    (!pa_deb_byp[1] && $past(!pa_deb_byp[1]) && $stable(pa_debounced_i[1]))
    |=> !pa_irq_pulse_o[1]
  ) else $error("raw pin reached a debounced interrupt path");

  a_deb_ignored: assert property (
    (pa_deb_byp[0] && $past(pa_deb_byp[0]) && $stable(pa_raw_i[0]))
    |=> !pa_irq_pulse_o[0]
  ) else $error("debouncer reached a bypassed interrupt path");

  a_edge_rise_pulse: assert property (
    (!pa_deb_byp[1] && $past(!pa_deb_byp[1]) && !pa_edge_sel[1] && $rose(pa_debounced_i[1]))
    |=> pa_irq_pulse_o[1]
  ) else $error("debounced rise gave no interrupt pulse");

  a_edge_fall_raw: assert property (
    (pa_deb_byp[0] && $past(pa_deb_byp[0]) && pa_edge_sel[0] && $fell(pa_raw_i[0]))
    |=> pa_irq_pulse_o[0]
  ) else $error("bypassed raw fall gave no interrupt pulse");

  // divided clocks stay low while their enable is clear
  a_clk_1k_off: assert property (
    !fsel[1]
    |=> !pb_clock_out_o[1]
  ) else $error("1 kHz output active while disabled");

  a_clk_32k_off: assert property (
    !fsel[2]
    |=> !pb_clock_out_o[2]
  ) else $error("32 kHz output active while disabled");

  a_clk_start_low: assert property (
    (fsel[0] && !$past(fsel[0]))
    |-> !pb_clock_out_o[0]
  ) else $error("1 Hz output not low when enabled");

  // combination reset: empty sets never hit, sleep gating
  a_combo_idle: assert property (
    !combo_now
    |=> !port_a_reset_o
  ) else $error("reset request without a selected combination");

  a_combo_second: assert property (
    (s_q.opt[S_COMBO2] != 4'h0 && (pa_raw_i & s_q.opt[S_COMBO2]) == s_q.opt[S_COMBO2]
     && (!sleep_i || fsel[`IORB_FSEL_WAKE_BIT]))
    |=> port_a_reset_o
  ) else $error("second combination set gave no reset");

  a_combo_empty: assert property (
    (s_q.opt[S_COMBO1] == 4'h0 && s_q.opt[S_COMBO2] == 4'h0)
    |=> !port_a_reset_o
  ) else $error("reset request with both combination sets empty");

  a_sleep_wake_pass: assert property (
    (sleep_i && fsel[`IORB_FSEL_WAKE_BIT] && combo_now)
    |=> port_a_reset_o
  ) else $error("wake enable did not pass the combination reset");

endmodule : iorb_option_bank

// [iorb_option_bank_tb_top.sv]
// self-checking testbench of the option register bank
`timescale 1ns/1ps

module iorb_option_bank_tb_top import iorb_pkg::*;;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  iorb_apb_req_t req = '0;
  iorb_apb_rsp_t rsp;
  logic [3:0] pa_raw = 4'h0;
  logic [3:0] pa_deb = 4'h0;
  logic sleep = 1'b0;
  logic [3:0] irq, pa_pu, pa_pd, pb_pu, pb_pd, pb_od, sp_od, sp_pd, seen;
  logic [2:0] clk_out;
  logic combo_rst;
  logic [31:0] rd;
  logic err;
  int err_total = 0;
  int compares = 0;

  // short dividers keep the clock-out check within a few dozen cycles
  iorb_option_bank #(.HALF_1HZ(4), .HALF_1KHZ(6)) uut (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .pa_raw_i(pa_raw), .pa_debounced_i(pa_deb), .sleep_i(sleep),
    .pa_irq_pulse_o(irq), .pa_pullup_en_o(pa_pu), .pa_pulldown_en_o(pa_pd),
    .pb_pullup_en_o(pb_pu), .pb_pulldown_en_o(pb_pd), .pb_open_drain_o(pb_od),
    .pb_clock_out_o(clk_out), .sp_open_drain_o(sp_od), .sp_pulldown_en_o(sp_pd),
    .port_a_reset_o(combo_rst)
  );

  // 200 MHz system clock
  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits on pready, only the watchdog ends a stuck wait
  task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] wd);
    @(posedge mclk_i);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= {3'h0, idx, 2'b00};
    req.pwdata <= wd;
    @(posedge mclk_i);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  // drive port A, collect interrupt pulses over a short window
  task automatic seek(input logic [3:0] raw, input logic [3:0] deb, input logic [3:0] exp);
    @(posedge mclk_i);
    pa_raw <= raw;
    pa_deb <= deb;
    seen = 4'h0;
    repeat (4) @(negedge mclk_i) seen |= irq;
    chk(32'(seen), 32'(exp));
  endtask : seek

  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  // cut a hang short well past the expected run length
  initial begin
    repeat (10000) @(posedge mclk_i);
    err_total++;
    wrap_up();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    // power-on contents and pull defaults
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 7'h75 + 7'(i), 32'h0);
      chk(rd, 32'h0);
    end
    @(negedge mclk_i);
    chk(32'({pa_pd, pb_pd, sp_pd, pb_pu, pa_pu}), 32'hFFF00);
    // upper write bits must not stick; readback is the stored nibble
    for (int i = 0; i < 10; i++) apb(1'b1, 7'h75 + 7'(i), {28'hABCDEF5, 4'(i + 1)});
    for (int i = 0; i < 10; i++) begin
      apb(1'b0, 7'h75 + 7'(i), 32'h0);
      chk({rd[30:0], err}, 32'(2 * (i + 1)));
    end
    @(negedge mclk_i);
    chk(32'({pa_pd, pb_pd, pb_pu, pb_od, sp_od, sp_pd, pa_pu}), 32'hCB55650);
    // unmapped place refuses, factory test place reads empty
    apb(1'b1, 7'h10, 32'hF);
    apb(1'b0, 7'h10, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, 7'h7F, 32'h0);
    chk({rd[30:0], err}, 32'h0);
    // a second power-on reset clears everything again
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    apb(1'b0, 7'h77, 32'h0);
    chk(rd, 32'h0);
    // interrupt source and edge selection
    apb(1'b1, 7'h75, 32'h1);
    seek(4'h1, 4'h0, 4'h1);
    seek(4'h0, 4'h0, 4'h0);
    seek(4'h2, 4'h0, 4'h0);
    seek(4'h0, 4'h2, 4'h2);
    apb(1'b1, 7'h76, 32'h3);
    seek(4'h1, 4'h2, 4'h0);
    seek(4'h0, 4'h2, 4'h1);
    seek(4'h0, 4'h0, 4'h2);
    seek(4'h0, 4'h4, 4'h4);
    seek(4'h0, 4'h0, 4'h0);
    // combination reset, gated in sleep unless enabled
    apb(1'b1, 7'h7C, 32'h3);
    seek(4'h3, 4'h0, 4'h0);
    chk(32'(combo_rst), 32'h1);
    @(posedge mclk_i);
    sleep <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk(32'(combo_rst), 32'h0);
    apb(1'b1, 7'h7B, 32'h8);
    repeat (3) @(negedge mclk_i);
    chk(32'(combo_rst), 32'h1);
    @(posedge mclk_i);
    pa_raw <= 4'h1;
    repeat (3) @(negedge mclk_i);
    chk(32'(combo_rst), 32'h0);
    apb(1'b1, 7'h7D, 32'h1);
    repeat (3) @(negedge mclk_i);
    chk(32'(combo_rst), 32'h1);
    // divided clocks run while enabled and stop when cleared
    apb(1'b1, 7'h7B, 32'h3);
    seen = 4'h0;
    repeat (30) @(negedge mclk_i) seen |= {1'b0, clk_out};
    chk(32'(seen), 32'h3);
    apb(1'b1, 7'h7B, 32'h0);
    repeat (2) @(negedge mclk_i);
    chk(32'(clk_out), 32'h0);
    // 32 kHz keeps its real half period: quiet at first, then high
    apb(1'b1, 7'h7B, 32'h4);
    seen = 4'h0;
    repeat (3000) @(negedge mclk_i) seen |= {1'b0, clk_out};
    chk(32'(seen), 32'h0);
    repeat (200) @(negedge mclk_i) seen |= {1'b0, clk_out};
    chk(32'(seen), 32'h4);
    wrap_up();
  end
endmodule : iorb_option_bank_tb_top
